// ===== s2md_defines.svh
`ifndef S2MD_DEFINES_SVH
`define S2MD_DEFINES_SVH

// ---------------------------------------------------------------
// APB register byte offsets
// ---------------------------------------------------------------
`define S2MD_CTRL_OFS 12'h000
`define S2MD_STAT_OFS 12'h004
`define S2MD_HEAD_OFS 12'h008
`define S2MD_DONE_OFS 12'h00c

// ---------------------------------------------------------------
// Register fields and reset values
// ---------------------------------------------------------------
`define S2MD_CTRL_RUN_BIT 0
`define S2MD_CTRL_RST 32'h0000_0000
`define S2MD_HEAD_RST 32'h0000_0000

// ---------------------------------------------------------------
// Descriptor layout in memory (word index, fields)
// ---------------------------------------------------------------
`define S2MD_DW_ADDR 2'h0
`define S2MD_DW_NEXT 2'h1
`define S2MD_DW_LEN 2'h2
`define S2MD_DW_CTRL 2'h3
`define S2MD_OWN_BIT 0
`define S2MD_FIXED_BIT 1
`define S2MD_EOPSEEN_BIT 2
`define S2MD_WORD_BYTES 32'h0000_0004

`endif

// ===== s2md_pkg.sv
package s2md_pkg;
    // Channel sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_FREQ  = 8'h02,
        ST_FWAIT = 8'h04,
        ST_CHECK = 8'h08,
        ST_XFER  = 8'h10,
        ST_WR    = 8'h20,
        ST_WB    = 8'h40,
        ST_SPARE = 8'h80
    } s2md_state_t;

    typedef logic [31:0] s2md_word_t;
endpackage

// ===== s2md_top.sv
`timescale 1ns/1ps
`include "s2md_defines.svh"

// What this block does
// - Zero length: move data until end-of-packet
// - Non-zero length: move exactly that many bytes
// - Fixed flag: every write to same address
// - Stream data goes to first write address
// - Run only when owned and run bit set
// - Follow next; wait for its ownership bit
module s2md_top (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire s2md_pkg::s2md_word_t I_PWDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output s2md_pkg::s2md_word_t O_PRDATA,
    // Stream sink
    input wire logic I_SNK_VALID,
    input wire s2md_pkg::s2md_word_t I_SNK_DATA,
    input wire logic I_SNK_EOP,
    input wire logic [1:0] I_SNK_EMPTY,
    output logic O_SNK_READY,
    // Chain read master
    output logic O_CRD_READ,
    output s2md_pkg::s2md_word_t O_CRD_ADDR,
    input wire logic I_CRD_WAITREQ,
    input wire logic I_CRD_RVALID,
    input wire s2md_pkg::s2md_word_t I_CRD_RDATA,
    // Chain write master
    output logic O_CWR_WRITE,
    output s2md_pkg::s2md_word_t O_CWR_ADDR,
    output s2md_pkg::s2md_word_t O_CWR_DATA,
    input wire logic I_CWR_WAITREQ,
    // Data write master
    output logic O_DWR_WRITE,
    output s2md_pkg::s2md_word_t O_DWR_ADDR,
    output s2md_pkg::s2md_word_t O_DWR_DATA,
    output logic [3:0] O_DWR_BYTEEN,
    input wire logic I_DWR_WAITREQ
);
    import s2md_pkg::*;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Byte enables for a word carrying cnt bytes (1..4)
    function automatic logic [3:0] be_of(input logic [2:0] cnt);
        case (cnt)
            3'h1: be_of = 4'h1;
            3'h2: be_of = 4'h3;
            3'h3: be_of = 4'h7;
            default: be_of = 4'hf;
        endcase
    endfunction

    // Address of one descriptor word
    function automatic s2md_word_t dw_addr(input s2md_word_t base, input logic [1:0] idx);
        dw_addr = base + {28'h0, idx, 2'h0};
    endfunction

    // ---------------------------------------------------------------
    // Register file state
    // ---------------------------------------------------------------
    logic run_reg, run_next;
    s2md_word_t done_reg, done_next;
    s2md_word_t prdata_reg, prdata_next;
    logic slverr_reg, slverr_next;

    // ---------------------------------------------------------------
    // Channel state
    // ---------------------------------------------------------------
    s2md_state_t state_reg, state_next;
    s2md_word_t cur_reg, cur_next;
    logic [1:0] idx_reg, idx_next;
    s2md_word_t waddr_reg, waddr_next;
    s2md_word_t nxt_reg, nxt_next;
    logic [15:0] len_reg, len_next;
    logic [15:0] cnt_reg, cnt_next;
    logic own_reg, own_next;
    logic fixed_reg, fixed_next;
    logic eop_reg, eop_next;
    s2md_word_t data_reg, data_next;
    logic [3:0] be_reg, be_next;
    logic [2:0] wbytes_reg, wbytes_next;
    logic last_reg, last_next;
    logic head_load;

    // APB setup and access phase decode
    logic apb_setup;
    logic apb_wr;
    assign apb_setup = I_PSEL & ~I_PENABLE;
    assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
    assign head_load = apb_wr && (I_PADDR == `S2MD_HEAD_OFS);

    // ---------------------------------------------------------------
    // APB registers: next values
    // ---------------------------------------------------------------
    always_comb begin
        run_next = run_reg;
        prdata_next = prdata_reg;
        slverr_next = slverr_reg;
        // Read data and error are prepared in the setup cycle
        if (apb_setup) begin
            prdata_next = 32'h0000_0000;
            slverr_next = 1'b0;
            case (I_PADDR)
                `S2MD_CTRL_OFS: prdata_next = {31'h0, run_reg};
                `S2MD_STAT_OFS: prdata_next = {cnt_reg, 15'h0, (state_reg != ST_IDLE)};
                `S2MD_HEAD_OFS: prdata_next = cur_reg;
                `S2MD_DONE_OFS: prdata_next = done_reg;
                default: slverr_next = 1'b1;
            endcase
        end
        // Writes take effect in the access cycle
        if (apb_wr && (I_PADDR == `S2MD_CTRL_OFS)) begin
            run_next = I_PWDATA[`S2MD_CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            run_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            prdata_reg <= prdata_next;
            slverr_reg <= slverr_next;
        end
    end

    // APB answers in the first access cycle
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = slverr_reg & I_PSEL & I_PENABLE;
    assign O_PRDATA = prdata_reg;

    // ---------------------------------------------------------------
    // Channel sequencer: next values
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        idx_next = idx_reg;
        waddr_next = waddr_reg;
        nxt_next = nxt_reg;
        len_next = len_reg;
        cnt_next = cnt_reg;
        own_next = own_reg;
        fixed_next = fixed_reg;
        eop_next = eop_reg;
        data_next = data_reg;
        be_next = be_reg;
        wbytes_next = wbytes_reg;
        last_next = last_reg;
        done_next = done_reg;
        case (state_reg)
            ST_IDLE: begin
                if (head_load) begin
                    cur_next = I_PWDATA;
                end else if (run_reg) begin
                    idx_next = 2'h0;
                    state_next = ST_FREQ;
                end
            end
            ST_FREQ: begin
                if (!I_CRD_WAITREQ) begin
                    state_next = ST_FWAIT;
                end
            end
            ST_FWAIT: begin
                if (I_CRD_RVALID) begin
                    case (idx_reg)
                        `S2MD_DW_ADDR: waddr_next = I_CRD_RDATA;
                        `S2MD_DW_NEXT: nxt_next = I_CRD_RDATA;
                        `S2MD_DW_LEN: len_next = I_CRD_RDATA[15:0];
                        default: begin
                            own_next = I_CRD_RDATA[`S2MD_OWN_BIT];
                            fixed_next = I_CRD_RDATA[`S2MD_FIXED_BIT];
                        end
                    endcase
                    idx_next = idx_reg + 2'h1;
                    state_next = (idx_reg == `S2MD_DW_CTRL) ? ST_CHECK : ST_FREQ;
                end
            end
            ST_CHECK: begin
                cnt_next = 16'h0000;
                eop_next = 1'b0;
                idx_next = 2'h0;
                if (!run_reg) begin
                    state_next = ST_IDLE;
                end else if (own_reg) begin
                    state_next = ST_XFER;
                end else begin
                    state_next = ST_FREQ;
                end
            end
            ST_XFER: begin
                if (I_SNK_VALID) begin
                    data_next = I_SNK_DATA;
                    if (len_reg == 16'h0000) begin
                        wbytes_next = 3'h4 - {1'b0, I_SNK_EMPTY};
                        last_next = I_SNK_EOP;
                        eop_next = I_SNK_EOP;
                    end else begin
                        wbytes_next = ((len_reg - cnt_reg) > 16'h0004) ? 3'h4 : 3'((len_reg - cnt_reg));
                        last_next = (len_reg - cnt_reg) <= 16'h0004;
                        eop_next = I_SNK_EOP;
                    end
                    be_next = be_of(((len_reg == 16'h0000) ? (3'h4 - {1'b0, I_SNK_EMPTY})
                        : (((len_reg - cnt_reg) > 16'h0004) ? 3'h4 : 3'((len_reg - cnt_reg)))));
                    state_next = ST_WR;
                end
            end
            ST_WR: begin
                if (!I_DWR_WAITREQ) begin
                    cnt_next = cnt_reg + {13'h0, wbytes_reg};
                    if (!fixed_reg) begin
                        waddr_next = waddr_reg + `S2MD_WORD_BYTES;
                    end
                    state_next = last_reg ? ST_WB : ST_XFER;
                end
            end
            ST_WB: begin
                if (!I_CWR_WAITREQ) begin
                    cur_next = nxt_reg;
                    done_next = done_reg + 32'h0000_0001;
                    idx_next = 2'h0;
                    state_next = ST_FREQ;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= ST_IDLE;
            cur_reg <= `S2MD_HEAD_RST;
            idx_reg <= 2'h0;
            waddr_reg <= 32'h0000_0000;
            nxt_reg <= 32'h0000_0000;
            len_reg <= 16'h0000;
            cnt_reg <= 16'h0000;
            own_reg <= 1'b0;
            fixed_reg <= 1'b0;
            eop_reg <= 1'b0;
            data_reg <= 32'h0000_0000;
            be_reg <= 4'h0;
            wbytes_reg <= 3'h0;
            last_reg <= 1'b0;
            done_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            idx_reg <= idx_next;
            waddr_reg <= waddr_next;
            nxt_reg <= nxt_next;
            len_reg <= len_next;
            cnt_reg <= cnt_next;
            own_reg <= own_next;
            fixed_reg <= fixed_next;
            eop_reg <= eop_next;
            data_reg <= data_next;
            be_reg <= be_next;
            wbytes_reg <= wbytes_next;
            last_reg <= last_next;
            done_reg <= done_next;
        end
    end

    // ---------------------------------------------------------------
    // Master and sink outputs
    // ---------------------------------------------------------------

    // Strobes follow the state; addresses and data from registers
    assign O_SNK_READY = (state_reg == ST_XFER);
    assign O_CRD_READ = (state_reg == ST_FREQ);
    assign O_CRD_ADDR = dw_addr(cur_reg, idx_reg);
    assign O_CWR_WRITE = (state_reg == ST_WB);
    assign O_CWR_ADDR = dw_addr(cur_reg, `S2MD_DW_CTRL);
    // Status word: byte count, end-of-packet seen, fixed kept, ownership cleared
    assign O_CWR_DATA = {cnt_reg, 13'h0, eop_reg, fixed_reg, 1'b0};
    assign O_DWR_WRITE = (state_reg == ST_WR);
    assign O_DWR_ADDR = waddr_reg;
    assign O_DWR_DATA = data_reg;
    assign O_DWR_BYTEEN = be_reg;
endmodule

// ===== s2md_top_assertions.sv
`timescale 1ns/1ps
module s2md_chk (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // Stream sink
    input wire logic I_SNK_VALID,
    input wire logic I_SNK_EOP,
    input wire logic O_SNK_READY,
    // Masters
    input wire logic O_CRD_READ,
    input wire s2md_pkg::s2md_word_t O_CRD_ADDR,
    input wire logic I_CRD_WAITREQ,
    input wire logic O_CWR_WRITE,
    input wire s2md_pkg::s2md_word_t O_CWR_DATA,
    input wire logic I_CWR_WAITREQ,
    input wire logic O_DWR_WRITE,
    input wire s2md_pkg::s2md_word_t O_DWR_ADDR,
    input wire s2md_pkg::s2md_word_t O_DWR_DATA,
    input wire logic I_DWR_WAITREQ
);
    import s2md_pkg::*;
    // ----------------
    // Port checks
    // ----------------
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    a_fetch_hold: assert property (O_CRD_READ && I_CRD_WAITREQ |=> O_CRD_READ && $stable(O_CRD_ADDR))
        else $error("chain read dropped");
    a_fetch_single: assert property (O_CRD_READ && !I_CRD_WAITREQ |=> !O_CRD_READ)
        else $error("second read outstanding");
    a_word_to_mem: assert property (I_SNK_VALID && O_SNK_READY |=> O_DWR_WRITE && !O_SNK_READY)
        else $error("no write after stream word");
    a_ready_no_wr: assert property (O_SNK_READY |-> !O_DWR_WRITE)
        else $error("ready while write pending");
    a_write_hold: assert property (O_DWR_WRITE && I_DWR_WAITREQ |=> $stable({O_DWR_ADDR, O_DWR_DATA}))
        else $error("data write changed while stalled");
    a_wb_release: assert property (O_CWR_WRITE |-> !O_CWR_DATA[0])
        else $error("write back keeps ownership");
    a_wb_hold: assert property (O_CWR_WRITE && I_CWR_WAITREQ |=> O_CWR_WRITE && $stable(O_CWR_DATA))
        else $error("write back dropped");
    a_next_fetch: assert property (O_CWR_WRITE && !I_CWR_WAITREQ |=> O_CRD_READ && !O_CWR_WRITE)
        else $error("next descriptor not fetched");
    c_eop: cover property (I_SNK_VALID && O_SNK_READY && I_SNK_EOP);
    c_wb: cover property (O_CWR_WRITE && !I_CWR_WAITREQ);
    c_stall: cover property (O_DWR_WRITE && I_DWR_WAITREQ);
endmodule

bind s2md_top s2md_chk u_chk (.*);

// ===== s2md_mem.sv
`timescale 1ns/1ps
module s2md_mem (
    // Clock and stall mode
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    // Chain read
    input wire logic i_rd,
    input wire s2md_pkg::s2md_word_t i_rd_addr,
    output logic o_rd_valid,
    output s2md_pkg::s2md_word_t o_rd_data,
    // Chain and data writes
    input wire logic i_cw,
    input wire s2md_pkg::s2md_word_t i_cw_addr,
    input wire s2md_pkg::s2md_word_t i_cw_data,
    input wire logic i_dw,
    input wire s2md_pkg::s2md_word_t i_dw_addr,
    input wire s2md_pkg::s2md_word_t i_dw_data,
    input wire logic [3:0] i_dw_be,
    // Shared stall
    output logic o_wait
);
    import s2md_pkg::*;
    s2md_word_t mem [0:255];
    logic stall_reg;
    assign o_wait = stall_reg;
    // Stalls every other cycle when slow; idle read data inverts so nothing stale looks valid
    // one shared memory
    always @(posedge i_clk) begin
        stall_reg <= i_rst_n & i_slow & ~stall_reg;
        o_rd_valid <= i_rd & ~o_wait;
        o_rd_data <= (i_rd & ~o_wait) ? mem[i_rd_addr[9:2]] : ~o_rd_data;
        if (i_cw & ~o_wait)
            mem[i_cw_addr[9:2]] <= i_cw_data;
        for (int b = 0; b < 4; b++)
            if (i_dw & ~o_wait & i_dw_be[b])
                mem[i_dw_addr[9:2]][8*b+:8] <= i_dw_data[8*b+:8];
    end
endmodule

// ===== s2md_top_tb.sv
`timescale 1ns/1ps
module s2md_top_tb;
    import s2md_pkg::*;
    logic I_SYS_CLK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR, I_SNK_VALID, I_SNK_EOP;
    logic O_SNK_READY, O_CRD_READ, I_CRD_WAITREQ, I_CRD_RVALID, O_CWR_WRITE, I_CWR_WAITREQ;
    logic O_DWR_WRITE, I_DWR_WAITREQ, slow, acc, err;
    logic [11:0] I_PADDR;
    logic [1:0] I_SNK_EMPTY;
    logic [3:0] O_DWR_BYTEEN;
    s2md_word_t I_PWDATA, O_PRDATA, I_SNK_DATA, O_CRD_ADDR, I_CRD_RDATA, O_CWR_ADDR, O_CWR_DATA;
    s2md_word_t O_DWR_ADDR, O_DWR_DATA, rd, seed, r;
    logic [34:0] sq[$];
    logic [67:0] ew[$];
    logic [63:0] ewb[$];
    int miscompares, samples_checked, nd, nc;
    // ----------------
    // Design and memory
    // ----------------
    s2md_top u_dut (.*);
    s2md_mem u_mem (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_slow(slow), .i_rd(O_CRD_READ),
        .i_rd_addr(O_CRD_ADDR), .o_rd_valid(I_CRD_RVALID), .o_rd_data(I_CRD_RDATA), .i_cw(O_CWR_WRITE),
        .i_cw_addr(O_CWR_ADDR), .i_cw_data(O_CWR_DATA), .i_dw(O_DWR_WRITE), .i_dw_addr(O_DWR_ADDR),
        .i_dw_data(O_DWR_DATA), .i_dw_be(O_DWR_BYTEEN), .o_wait(I_CRD_WAITREQ));
    assign I_CWR_WAITREQ = I_CRD_WAITREQ;
    assign I_DWR_WAITREQ = I_CRD_WAITREQ;
    always #5 I_SYS_CLK = ~I_SYS_CLK;
    function automatic s2md_word_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string name, input logic [67:0] exp, input logic [67:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // APB transfer, starting just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input s2md_word_t wd);
        I_PSEL <= 1'b1;
        I_PWRITE <= wr;
        I_PADDR <= a;
        I_PWDATA <= wd;
        @(posedge I_SYS_CLK);
        I_PENABLE <= 1'b1;
        do @(posedge I_SYS_CLK); while (O_PREADY !== 1'b1);
        rd = O_PRDATA;
        err = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
        // One idle edge so the next call never re-drives psel in this step
        @(posedge I_SYS_CLK);
    endtask
    // Reference model: places a descriptor, queues its stream words and the writes they imply
    task automatic mk(input s2md_word_t base, dst, nxt, input int len, input logic fx, own, input int nw, emp);
        int n, k, t;
        s2md_word_t d;
        n = (len > 0) ? (len + 3) / 4 : nw;
        t = 0;
        for (int i = 0; i < n; i++) begin
            d = rnd();
            k = (len > 0) ? ((len - t > 4) ? 4 : len - t) : ((i == n - 1) ? 4 - emp : 4);
            t += k;
            sq.push_back({len == 0 && i == n - 1, (len == 0 && i == n - 1) ? emp[1:0] : 2'h0, d});
            ew.push_back({dst + (fx ? 32'h0 : 32'(4 * i)), d, 4'((1 << k) - 1)});
        end
        ewb.push_back({base + 32'hc, 16'(t), 13'h0, len == 0, fx, 1'b0});
        u_mem.mem[base[9:2]] = dst;
        u_mem.mem[base[9:2] + 8'h1] = nxt;
        u_mem.mem[base[9:2] + 8'h2] = 32'(len);
        u_mem.mem[base[9:2] + 8'h3] = {30'h0, fx, own};
    endtask
    task automatic wait_for(input int wd, input int wc);
        for (int i = 0; i < 3000 && (nd < wd || nc < wc); i++) @(posedge I_SYS_CLK);
        // A wait that runs out counts as a mismatch
        if (nd < wd || nc < wc) begin
            miscompares++;
            $display("[FAIL] wait expected %0d %0d seen %0d %0d", wd, wc, nd, nc);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Samples stream acceptance and checks every accepted memory write
    always @(negedge I_SYS_CLK) begin
        acc <= I_SNK_VALID & O_SNK_READY;
        if (O_DWR_WRITE & !I_DWR_WAITREQ) begin
            nd++;
            chk("data write", ew.size() ? ew.pop_front() : '1, {O_DWR_ADDR, O_DWR_DATA, O_DWR_BYTEEN});
        end
        if (O_CWR_WRITE & !I_CWR_WAITREQ) begin
            nc++;
            chk("write back", ewb.size() ? ewb.pop_front() : '1, {O_CWR_ADDR, O_CWR_DATA});
        end
    end
    // Offers queued stream words with random gaps, holding each until taken
    always @(posedge I_SYS_CLK) begin
        if (acc)
            void'(sq.pop_front());
        if (acc || !I_SNK_VALID) begin
            r = rnd();
            I_SNK_VALID <= I_RST_N && sq.size() > 0 && r[0];
            {I_SNK_EOP, I_SNK_EMPTY, I_SNK_DATA} <= (sq.size() > 0) ? sq[0] : ~{I_SNK_EOP, I_SNK_EMPTY, I_SNK_DATA};
        end
    end
    // Hang guard
    initial begin
        #100us;
        miscompares++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        I_SYS_CLK = 1'b0;
        I_RST_N = 1'b0;
        {I_PSEL, I_PENABLE, I_PWRITE, I_SNK_VALID, I_SNK_EOP, slow, acc} = '0;
        {I_PADDR, I_PWDATA, I_SNK_EMPTY, I_SNK_DATA} = '0;
        seed = 32'h00009d48;
        mk(32'h100, 32'h200, 32'h110, 10, 1'b0, 1'b1, 0, 0);
        mk(32'h110, 32'h300, 32'h120, 0, 1'b1, 1'b1, 3, 1);
        mk(32'h120, 32'h340, 32'h130, 5, 1'b0, 1'b0, 0, 0);
        u_mem.mem[8'h4f] = 32'h0;
        repeat (8) @(posedge I_SYS_CLK);
        I_RST_N <= 1'b1;
        @(posedge I_SYS_CLK);
        apb(1'b1, 12'h008, 32'h100);
        apb(1'b0, 12'h008, 32'h0);
        chk("head", 32'h100, rd);
        repeat (20) @(posedge I_SYS_CLK);
        chk("writes without run", 0, nd);
        apb(1'b1, 12'h000, 32'h1);
        wait_for(6, 2);
        repeat (60) @(posedge I_SYS_CLK);
        chk("writes before owned", 6, nd);
        slow <= 1'b1;
        u_mem.mem[8'h4b] <= 32'h1;
        wait_for(8, 3);
        chk("writes after owned", {nd, nc}, {32'd8, 32'd3});
        apb(1'b0, 12'h00c, 32'h0);
        chk("done count", 3, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {err, rd}, {1'b1, 32'h0});
        repeat (30) @(posedge I_SYS_CLK);
        apb(1'b0, 12'h004, 32'h0);
        chk("status polling", 32'h1, rd);
        apb(1'b1, 12'h000, 32'h0);
        repeat (30) @(posedge I_SYS_CLK);
        apb(1'b0, 12'h004, 32'h0);
        chk("status stopped", 32'h0, rd);
        chk("leftovers", 0, ew.size() + ewb.size() + sq.size());
        report_and_stop();
    end
endmodule
